// File: hdl/amp_regs_pkg.sv
// constants, register map and carrier types for the amplifier register group
package amp_regs_pkg;

  localparam int unsigned CLK_NS = 8;

  // register offsets
  localparam logic [7:0] OFS_HIGH_RAIL_MSB  = 8'h54;
  localparam logic [7:0] OFS_HIGH_RAIL_LSB  = 8'h55;
  localparam logic [7:0] OFS_TEMPERATURE    = 8'h56;
  localparam logic [7:0] OFS_HALT_IRQ_CFG   = 8'h5C;
  localparam logic [7:0] OFS_IRQ_POLARITY   = 8'h5D;
  localparam logic [7:0] OFS_FRAME_RATIO    = 8'h60;
  localparam logic [7:0] OFS_IDLE_INDUCTOR  = 8'h63;
  localparam logic [7:0] OFS_LIMITER_SOURCE = 8'h65;
  localparam logic [7:0] OFS_IDLE_HYST      = 8'h67;
  localparam logic [7:0] OFS_DETECTED_RATIO = 8'h68;
  localparam logic [7:0] OFS_SWITCH_DELAYS  = 8'h6A;

  // reset values
  localparam logic [7:0] RST_HALT_IRQ_CFG   = 8'h19;
  localparam logic [7:0] RST_IRQ_POLARITY   = 8'h80;
  localparam logic [7:0] RST_FRAME_RATIO    = 8'h0D;
  localparam logic [7:0] RST_IDLE_INDUCTOR  = 8'h48;
  localparam logic [7:0] RST_LIMITER_SOURCE = 8'h08;
  localparam logic [7:0] RST_IDLE_HYST      = 8'h00;
  localparam logic [7:0] RST_DETECTED_RATIO = 8'h30;
  localparam logic [7:0] RST_SWITCH_DELAYS  = 8'h12;

  // field positions
  localparam int unsigned POS_CLK_PWR     = 7;
  localparam int unsigned POS_HALT_DIS    = 6;
  localparam int unsigned POS_HALT_CODE   = 3;
  localparam int unsigned POS_IRQ_CLR     = 2;
  localparam int unsigned POS_IRQ_MODE    = 0;
  localparam int unsigned POS_TOP_BIT     = 7;
  localparam int unsigned POS_RATIO_SET   = 2;
  localparam int unsigned POS_RATIO_DET   = 0;
  localparam int unsigned POS_IDLE_HYST   = 0;
  localparam int unsigned POS_SW_DELAY    = 6;
  localparam int unsigned POS_LVS_DELAY   = 4;
  localparam int unsigned POS_LVS_HEAD    = 0;

  // highest ratio code that is not reserved
  localparam logic [5:0] RATIO_CODE_MAX = 6'h0D;

  typedef enum logic [1:0] {
    PIN_LIVE         = 2'h0,
    PIN_LATCHED      = 2'h1,
    PIN_PULSE_EVENT  = 2'h2,
    PIN_PULSE_REPEAT = 2'h3
  } pin_mode_t;

  // clock halt timeouts in ns, codes 0..7
  localparam int unsigned HALT_NS [8] = '{820_000, 3_270_000, 26_210_000,
    52_420_000, 104_850_000, 209_710_000, 419_430_000, 838_860_000};

  function automatic int unsigned halt_cyc(input int unsigned i);
    halt_cyc = (HALT_NS[i] / CLK_NS > 0) ? HALT_NS[i] / CLK_NS : 1;
  endfunction

  localparam int unsigned HALT_CYC_DEF [8] = '{halt_cyc(0), halt_cyc(1),
    halt_cyc(2), halt_cyc(3), halt_cyc(4), halt_cyc(5), halt_cyc(6),
    halt_cyc(7)};

  // pin pulse timing: 1 ms tick, pulse of 3 ticks, repeat every 4 ticks
  localparam int unsigned MS_NS        = 1_000_000;
  localparam int unsigned MS_CYC_DEF   = MS_NS / CLK_NS;
  localparam logic [1:0]  PULSE_TICKS  = 2'h3;

  typedef struct packed {
    logic       clock_driven_power_control;
    logic       halt_detect_disable;
    logic [2:0] halt_code;
    pin_mode_t  interrupt_pin_mode;
    logic       interrupt_pin_polarity;
    logic [5:0] frame_ratio_setting;
    logic       idle_inductor_select;
    logic       limiter_source_select;
    logic [1:0] idle_hysteresis_timer;
    logic [1:0] supply_switch_delay;
    logic [1:0] low_voltage_signal_delay;
    logic [3:0] low_voltage_signal_headroom;
  } amp_cfg_t;

  typedef struct packed {
    logic [11:0] high_rail_result;
    logic [7:0]  temperature_result;
  } cnv_result_t;

endpackage

// File: hdl/clock_halt_timer.sv
// counts cycles while armed and flags expiry at the selected limit
`timescale 1ns/10ps
module clock_halt_timer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_run,
  input  wire logic [31:0] i_limit,
  output logic             o_expired
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        exp_q;
  logic        exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (!i_run) begin
      cnt_d = '0;
      exp_d = 1'b0;
    end else if (!exp_q) begin
      if (cnt_q + 32'h1 >= i_limit) begin
        exp_d = 1'b1;
      end
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign o_expired = exp_q;

endmodule

// File: hdl/amp_monitor_clock_irq_regs.sv
// supply/temperature readout, clock halt handling, interrupt pin, settings
`timescale 1ns/10ps
module amp_monitor_clock_irq_regs
  import amp_regs_pkg::*;
#(
  parameter int unsigned IRQ_W             = 8,
  parameter int unsigned HALT_CYC [8]      = amp_regs_pkg::HALT_CYC_DEF,
  parameter int unsigned MS_CYC            = amp_regs_pkg::MS_CYC_DEF
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  output logic [7:0]                     o_reg_rdata,
  input  wire amp_regs_pkg::cnv_result_t i_cnv,
  input  wire logic                      i_cnv_valid,
  input  wire logic [IRQ_W-1:0]          i_irq_live,
  input  wire logic [IRQ_W-1:0]          i_irq_mask,
  input  wire logic                      i_audio_clk_present,
  input  wire logic                      i_auto_rate_off,
  input  wire logic [5:0]                i_ratio_detected,
  input  wire logic                      i_ratio_detected_valid,
  input  wire logic                      i_rate_invalid,
  input  wire logic                      i_rate_changed,
  output amp_regs_pkg::amp_cfg_t         o_cfg,
  output logic [IRQ_W-1:0]               o_irq_latched,
  output logic                           o_interrupt_pin,
  output logic                           o_clock_error,
  output logic                           o_clock_halted,
  output logic                           o_power_up
);

  if (IRQ_W < 1 || MS_CYC < 1) begin : g_chk
    $error("amp_monitor_clock_irq_regs: bad IRQ_W or MS_CYC");
  end

  // ---------------- register file ----------------
  logic [7:0]  halt_cfg_q, halt_cfg_d;
  logic        pol_q, pol_d;
  logic [5:0]  ratio_set_q, ratio_set_d;
  logic        idle_inductor_select_q, idle_inductor_select_d;
  logic        lim_src_q, lim_src_d;
  logic [1:0]  hyst_q, hyst_d;
  logic [5:0]  ratio_det_q, ratio_det_d;
  logic [7:0]  delays_q, delays_d;
  cnv_result_t cnv_q, cnv_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        clr_pulse;

  always_comb begin
    halt_cfg_d  = halt_cfg_q;
    pol_d       = pol_q;
    ratio_set_d = ratio_set_q;
    idle_inductor_select_d  = idle_inductor_select_q;
    lim_src_d   = lim_src_q;
    hyst_d      = hyst_q;
    ratio_det_d = ratio_det_q;
    delays_d    = delays_q;
    cnv_d       = cnv_q;
    rdata_d     = rdata_q;
    clr_pulse   = 1'b0;
    if (i_cnv_valid) begin
      cnv_d = i_cnv;
    end
    if (i_reg_wr) begin
      case (i_reg_addr)
        OFS_HALT_IRQ_CFG: begin
          halt_cfg_d = i_reg_wdata;
          halt_cfg_d[POS_IRQ_CLR] = 1'b0;
          clr_pulse = i_reg_wdata[POS_IRQ_CLR];
        end
        OFS_IRQ_POLARITY:   pol_d = i_reg_wdata[POS_TOP_BIT];
        OFS_FRAME_RATIO: begin
          ratio_set_d = i_reg_wdata[POS_RATIO_SET +: 6];
        end
        OFS_IDLE_INDUCTOR:  idle_inductor_select_d = i_reg_wdata[POS_TOP_BIT];
        OFS_LIMITER_SOURCE: lim_src_d = i_reg_wdata[POS_TOP_BIT];
        OFS_IDLE_HYST: begin
          hyst_d = i_reg_wdata[POS_IDLE_HYST +: 2];
        end
        OFS_DETECTED_RATIO: begin
          ratio_det_d = i_reg_wdata[POS_RATIO_DET +: 6];
        end
        OFS_SWITCH_DELAYS:  delays_d = i_reg_wdata;
        default: ;
      endcase
    end
    // hardware detection wins over a software write in the same cycle
    if (i_ratio_detected_valid) begin
      ratio_det_d = i_ratio_detected;
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        OFS_HIGH_RAIL_MSB:  rdata_d = cnv_q.high_rail_result[11:4];
        OFS_HIGH_RAIL_LSB: begin
          rdata_d = {cnv_q.high_rail_result[3:0], 4'h0};
        end
        OFS_TEMPERATURE:    rdata_d = cnv_q.temperature_result;
        OFS_HALT_IRQ_CFG:   rdata_d = halt_cfg_q;
        OFS_IRQ_POLARITY: begin
          rdata_d = {pol_q, RST_IRQ_POLARITY[6:0]};
        end
        OFS_FRAME_RATIO: begin
          rdata_d = {ratio_set_q, RST_FRAME_RATIO[1:0]};
        end
        OFS_IDLE_INDUCTOR: begin
          rdata_d = {idle_inductor_select_q, RST_IDLE_INDUCTOR[6:0]};
        end
        OFS_LIMITER_SOURCE: begin
          rdata_d = {lim_src_q, RST_LIMITER_SOURCE[6:0]};
        end
        OFS_IDLE_HYST:      rdata_d = {RST_IDLE_HYST[7:2], hyst_q};
        OFS_DETECTED_RATIO: begin
          rdata_d = {RST_DETECTED_RATIO[7:6], ratio_det_q};
        end
        OFS_SWITCH_DELAYS:  rdata_d = delays_q;
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      halt_cfg_q  <= RST_HALT_IRQ_CFG;
      pol_q       <= RST_IRQ_POLARITY[POS_TOP_BIT];
      ratio_set_q <= RST_FRAME_RATIO[POS_RATIO_SET +: 6];
      idle_inductor_select_q  <= RST_IDLE_INDUCTOR[POS_TOP_BIT];
      lim_src_q   <= RST_LIMITER_SOURCE[POS_TOP_BIT];
      hyst_q      <= RST_IDLE_HYST[POS_IDLE_HYST +: 2];
      ratio_det_q <= RST_DETECTED_RATIO[POS_RATIO_DET +: 6];
      delays_q    <= RST_SWITCH_DELAYS;
      cnv_q       <= '0;
      rdata_q     <= 8'h00;
    end else begin
      halt_cfg_q  <= halt_cfg_d;
      pol_q       <= pol_d;
      ratio_set_q <= ratio_set_d;
      idle_inductor_select_q  <= idle_inductor_select_d;
      lim_src_q   <= lim_src_d;
      hyst_q      <= hyst_d;
      ratio_det_q <= ratio_det_d;
      delays_q    <= delays_d;
      cnv_q       <= cnv_d;
      rdata_q     <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  always_comb begin
    o_cfg.clock_driven_power_control  = halt_cfg_q[POS_CLK_PWR];
    o_cfg.halt_detect_disable         = halt_cfg_q[POS_HALT_DIS];
    o_cfg.halt_code                   = halt_cfg_q[POS_HALT_CODE +: 3];
    o_cfg.interrupt_pin_mode = pin_mode_t'(halt_cfg_q[POS_IRQ_MODE +: 2]);
    o_cfg.interrupt_pin_polarity      = pol_q;
    o_cfg.frame_ratio_setting         = ratio_set_q;
    o_cfg.idle_inductor_select        = idle_inductor_select_q;
    o_cfg.limiter_source_select       = lim_src_q;
    o_cfg.idle_hysteresis_timer       = hyst_q;
    o_cfg.supply_switch_delay         = delays_q[POS_SW_DELAY +: 2];
    o_cfg.low_voltage_signal_delay    = delays_q[POS_LVS_DELAY +: 2];
    o_cfg.low_voltage_signal_headroom = delays_q[POS_LVS_HEAD +: 4];
  end

  // ---------------- clock error, halt and power ----------------
  logic clk_meta_q, clk_sync_q;
  logic clk_err_q, clk_err_d;
  logic [5:0] ratio_prev_q, ratio_prev_d;
  logic       ratio_seen_q, ratio_seen_d;
  logic       halt_run;
  logic       halt_expired;
  logic [31:0] halt_limit;
  logic       ratio_bad;

  // pin-side clock presence: first stage feeds only the second
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_meta_q <= 1'b0;
      clk_sync_q <= 1'b0;
    end else begin
      clk_meta_q <= i_audio_clk_present;
      clk_sync_q <= clk_meta_q;
    end
  end

  always_comb begin
    ratio_prev_d = ratio_prev_q;
    ratio_seen_d = ratio_seen_q;
    clk_err_d    = clk_err_q;
    // reserved detected code, or mismatch with the fixed setting
    ratio_bad = i_ratio_detected_valid &&
      ((i_ratio_detected > RATIO_CODE_MAX) ||
       (i_auto_rate_off && i_ratio_detected != ratio_set_q));
    if (i_ratio_detected_valid) begin
      ratio_prev_d = i_ratio_detected;
      ratio_seen_d = 1'b1;
    end
    // error holds while clocks are present, clears once they are gone
    // and the halt handling has been given its chance
    if (ratio_bad || i_rate_invalid || i_rate_changed ||
        (i_ratio_detected_valid && ratio_seen_q &&
         i_ratio_detected != ratio_prev_q)) begin
      clk_err_d = 1'b1;
    end else if (clk_sync_q == 1'b0 && halt_expired) begin
      clk_err_d = 1'b0;
    end else if (clk_sync_q == 1'b0 &&
                 halt_cfg_q[POS_HALT_DIS]) begin
      clk_err_d = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ratio_prev_q <= 6'h00;
      ratio_seen_q <= 1'b0;
      clk_err_q    <= 1'b0;
    end else begin
      ratio_prev_q <= ratio_prev_d;
      ratio_seen_q <= ratio_seen_d;
      clk_err_q    <= clk_err_d;
    end
  end

  assign halt_limit = 32'(HALT_CYC[halt_cfg_q[POS_HALT_CODE +: 3]]);
  // timer runs only after an error, with detection on and clocks gone
  assign halt_run = clk_err_q && !halt_cfg_q[POS_HALT_DIS] &&
                    !clk_sync_q;

  clock_halt_timer u_halt (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_run     (halt_run),
    .i_limit   (halt_limit),
    .o_expired (halt_expired)
  );

  logic halted_q, halted_d;
  logic pwr_q, pwr_d;

  always_comb begin
    halted_d = halted_q;
    if (clk_sync_q) begin
      halted_d = 1'b0;
    end else if (halt_expired) begin
      halted_d = 1'b1;
    end
    // automatic mode tracks the clocks; otherwise stay powered
    pwr_d = halt_cfg_q[POS_CLK_PWR] ? (clk_sync_q && !halted_d)
                                    : 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      halted_q <= 1'b0;
      pwr_q    <= 1'b0;
    end else begin
      halted_q <= halted_d;
      pwr_q    <= pwr_d;
    end
  end

  assign o_clock_error  = clk_err_q;
  assign o_clock_halted = halted_q;
  assign o_power_up     = pwr_q;

  // ---------------- interrupt latches and pin ----------------
  logic [IRQ_W-1:0] latch_q, latch_d;
  logic [IRQ_W-1:0] live_prev_q;
  logic [IRQ_W-1:0] new_event;

  for (genvar g = 0; g < IRQ_W; g++) begin : g_latch
    // a flag raised in the clearing cycle survives the clear
    assign latch_d[g] = (clr_pulse ? 1'b0 : latch_q[g]) |
                        i_irq_live[g];
    assign new_event[g] = i_irq_live[g] & ~live_prev_q[g] & ~i_irq_mask[g];
  end

  logic [31:0] div_q, div_d;
  logic        ms_tick;
  logic [1:0]  phase_q, phase_d;
  logic [1:0]  pulse_q, pulse_d;
  logic        act_q, act_d;
  logic        pin_q;
  logic        any_live, any_latched;

  always_comb begin
    any_live    = |(i_irq_live & ~i_irq_mask);
    any_latched = |(latch_q & ~i_irq_mask);
    ms_tick     = (div_q == 32'(MS_CYC - 1));
    div_d       = ms_tick ? 32'h0 : div_q + 32'h1;
    phase_d     = ms_tick ? phase_q + 2'h1 : phase_q;
    pulse_d     = pulse_q;
    if (ms_tick && pulse_q != 2'h0) begin
      pulse_d = pulse_q - 2'h1;
    end
    // three whole-ms ticks: active between 2 and 3 ms
    case (o_cfg.interrupt_pin_mode)
      PIN_PULSE_EVENT: begin
        if (|new_event && pulse_q == 2'h0) begin
          pulse_d = PULSE_TICKS;
        end
      end
      PIN_PULSE_REPEAT: begin
        if (any_latched && ms_tick && phase_q == 2'h3) begin
          pulse_d = PULSE_TICKS;
        end
      end
      default: pulse_d = 2'h0;
    endcase
    case (o_cfg.interrupt_pin_mode)
      PIN_LIVE:    act_d = any_live;
      PIN_LATCHED: act_d = any_latched;
      default:     act_d = (pulse_d != 2'h0);
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_q     <= '0;
      live_prev_q <= '0;
      div_q       <= '0;
      phase_q     <= 2'h0;
      pulse_q     <= 2'h0;
      act_q       <= 1'b0;
      pin_q       <= RST_IRQ_POLARITY[POS_TOP_BIT];
    end else begin
      latch_q     <= latch_d;
      live_prev_q <= i_irq_live;
      div_q       <= div_d;
      phase_q     <= phase_d;
      pulse_q     <= pulse_d;
      act_q       <= act_d;
      pin_q       <= act_d ^ pol_q;
    end
  end

  assign o_irq_latched   = latch_q;
  assign o_interrupt_pin = pin_q;

endmodule

// File: tb/amp_monitor_clock_irq_regs_asserts.sv
// port checker for the amplifier register group
`timescale 1ns/10ps
module amp_monitor_clock_irq_regs_asserts
  import amp_regs_pkg::*;
#(
  parameter int unsigned IRQ_W        = 8,
  parameter int unsigned HALT_CYC [8] = amp_regs_pkg::HALT_CYC_DEF,
  parameter int unsigned MS_CYC       = amp_regs_pkg::MS_CYC_DEF
) (
  input wire logic                      i_ref_clk,
  input wire logic                      i_rst,
  input wire logic [7:0]                i_reg_addr,
  input wire logic [7:0]                i_reg_wdata,
  input wire logic                      i_reg_wr,
  input wire logic                      i_reg_rd,
  input wire logic [7:0]                o_reg_rdata,
  input wire logic [IRQ_W-1:0]          i_irq_live,
  input wire logic [IRQ_W-1:0]          i_irq_mask,
  input wire logic                      i_rate_invalid,
  input wire logic                      i_rate_changed,
  input wire amp_regs_pkg::amp_cfg_t    o_cfg,
  input wire logic [IRQ_W-1:0]          o_irq_latched,
  input wire logic                      o_interrupt_pin,
  input wire logic                      o_clock_error,
  input wire logic                      o_clock_halted,
  input wire logic                      o_power_up
);
  import amp_regs_pkg::*;
  logic live_act;
  logic latch_act;
  logic pol;
  logic clr_wr;
  assign live_act = |(i_irq_live & ~i_irq_mask);
  assign latch_act = |(o_irq_latched & ~i_irq_mask);
  assign pol = o_cfg.interrupt_pin_polarity;
  assign clr_wr = i_reg_wr && i_reg_addr == OFS_HALT_IRQ_CFG && i_reg_wdata[2];

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_live_pin_follow: assert property (o_cfg.interrupt_pin_mode == PIN_LIVE
    |=> o_interrupt_pin == ($past(live_act) ^ $past(pol)))
    else $error("pin does not follow live sources");
  chk_latch_pin_follow: assert property (
    o_cfg.interrupt_pin_mode == PIN_LATCHED
    |=> o_interrupt_pin == ($past(latch_act) ^ $past(pol)))
    else $error("pin does not follow latched flags");
  chk_latch_holds: assert property (!clr_wr
    |=> (o_irq_latched & $past(o_irq_latched)) == $past(o_irq_latched))
    else $error("latched flag lost without clear");
  chk_latch_sets: assert property (live_act
    |=> ((o_irq_latched & $past(i_irq_live & ~i_irq_mask))
         == $past(i_irq_live & ~i_irq_mask)))
    else $error("live source not latched");
  chk_clear_empties: assert property (clr_wr && i_irq_live == '0
    |=> o_irq_latched == '0)
    else $error("latches not cleared");
  chk_clear_reads_zero: assert property (
    i_reg_rd && i_reg_addr == OFS_HALT_IRQ_CFG |=> !o_reg_rdata[2])
    else $error("clear bit reads one");
  chk_pol_reserved_zero: assert property (
    i_reg_rd && i_reg_addr == OFS_IRQ_POLARITY |=> o_reg_rdata[6:0] == 7'h00)
    else $error("reserved polarity bits not zero");
  chk_lsb_nibble_zero: assert property (
    i_reg_rd && i_reg_addr == OFS_HIGH_RAIL_LSB |=> o_reg_rdata[3:0] == 4'h0)
    else $error("high rail low nibble not zero");
  chk_error_on_fault: assert property ((i_rate_invalid || i_rate_changed)
    && !o_clock_halted && !o_cfg.halt_detect_disable |=> o_clock_error)
    else $error("clock error not flagged");
  chk_manual_power_on: assert property (
    !o_cfg.clock_driven_power_control |=> o_power_up)
    else $error("power low with automatic mode off");
  chk_auto_power_halt: assert property (
    o_cfg.clock_driven_power_control && o_clock_halted
    |=> !o_power_up || !o_clock_halted)
    else $error("power stays up while halted");
  chk_halt_needs_enable: assert property ($rose(o_clock_halted)
    |-> !$past(o_cfg.halt_detect_disable))
    else $error("halt seen with detection off");

  cover property (o_cfg.interrupt_pin_mode == PIN_PULSE_EVENT
    && $changed(o_interrupt_pin));
  cover property (o_cfg.interrupt_pin_mode == PIN_PULSE_REPEAT
    && $changed(o_interrupt_pin));
  cover property ($rose(o_clock_halted));
  cover property (clr_wr && o_irq_latched != '0);
endmodule

bind amp_monitor_clock_irq_regs amp_monitor_clock_irq_regs_asserts #(
  .IRQ_W(IRQ_W), .HALT_CYC(HALT_CYC), .MS_CYC(MS_CYC)
) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_irq_live(i_irq_live),
  .i_irq_mask(i_irq_mask), .i_rate_invalid(i_rate_invalid),
  .i_rate_changed(i_rate_changed), .o_cfg(o_cfg),
  .o_irq_latched(o_irq_latched), .o_interrupt_pin(o_interrupt_pin),
  .o_clock_error(o_clock_error), .o_clock_halted(o_clock_halted),
  .o_power_up(o_power_up)
);

// File: tb/amp_monitor_clock_irq_regs_test.sv
// self-checking bench for the amplifier register group
`timescale 1ns/10ps
module amp_monitor_clock_irq_regs_test;
  import amp_regs_pkg::*;
  // short halt limits, one per code, so the timeout choice is visible
  localparam int unsigned HC [8] = '{10, 12, 14, 16, 18, 20, 22, 24};
  localparam logic [7:0] OFS [12] = '{8'h54, 8'h55, 8'h56, 8'h5C, 8'h5D,
    8'h60, 8'h63, 8'h65, 8'h67, 8'h68, 8'h6A, 8'h57};
  localparam logic [7:0] RV [12] = '{8'h00, 8'h00, 8'h00, 8'h19, 8'h80,
    8'h0D, 8'h48, 8'h08, 8'h00, 8'h30, 8'h12, 8'h00};
  localparam logic [7:0] WV [12] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h37, 8'hFF, 8'hFF, 8'hFF, 8'hCD, 8'hFF, 8'hFF};
  localparam logic [7:0] RW [12] = '{8'h00, 8'h00, 8'h00, 8'hFB, 8'h80,
    8'h35, 8'hC8, 8'h88, 8'h03, 8'h0D, 8'hFF, 8'h00};
  localparam logic [7:0] RZ [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h48, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  cnv_result_t i_cnv = '0;
  logic        i_cnv_valid = 1'b0;
  logic [7:0]  i_irq_live = 8'h00;
  logic [7:0]  i_irq_mask = 8'h00;
  logic        i_audio_clk_present = 1'b0;
  logic        i_auto_rate_off = 1'b0;
  logic [5:0]  i_ratio_detected = 6'h00;
  logic        i_ratio_detected_valid = 1'b0;
  logic        i_rate_invalid = 1'b0;
  logic        i_rate_changed = 1'b0;
  logic [7:0]  o_reg_rdata;
  amp_cfg_t    o_cfg;
  logic [7:0]  o_irq_latched;
  logic        o_interrupt_pin;
  logic        o_clock_error;
  logic        o_clock_halted;
  logic        o_power_up;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  amp_monitor_clock_irq_regs #(.HALT_CYC(HC), .MS_CYC(10)) dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_cnv(i_cnv), .i_cnv_valid(i_cnv_valid),
    .i_irq_live(i_irq_live), .i_irq_mask(i_irq_mask),
    .i_audio_clk_present(i_audio_clk_present),
    .i_auto_rate_off(i_auto_rate_off), .i_ratio_detected(i_ratio_detected),
    .i_ratio_detected_valid(i_ratio_detected_valid),
    .i_rate_invalid(i_rate_invalid), .i_rate_changed(i_rate_changed),
    .o_cfg(o_cfg), .o_irq_latched(o_irq_latched),
    .o_interrupt_pin(o_interrupt_pin), .o_clock_error(o_clock_error),
    .o_clock_halted(o_clock_halted), .o_power_up(o_power_up)
  );

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic do_reset();
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick(1);
    i_reg_wr = 1'b0;
    // idle edge so a following call never re-raises the strobe at once
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, exp);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    tick(1);
    i_reg_rd = 1'b0;
    chk($sformatf("register %h", a), exp, o_reg_rdata);
    tick(1);
  endtask

  // counts cycles while the pin stays at v, up to lim
  task automatic run_len(input logic v, input int lim, output int n);
    n = 0;
    while (o_interrupt_pin === v && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_regs();
    do_reset();
    chk("cfg reset", {2'h0, 3'h3, 2'h1, 1'b1, 6'h03, 6'h00, 2'h1, 4'h2},
      o_cfg);
    for (int i = 0; i < 12; i++) rd(OFS[i], RV[i]);
    for (int i = 0; i < 12; i++) wr(OFS[i], WV[i]);
    for (int i = 0; i < 12; i++) rd(OFS[i], RW[i]);
    chk("cfg written", {2'h3, 3'h7, 2'h3, 1'b1, 6'h0D, 12'hFFF}, o_cfg);
    for (int i = 0; i < 12; i++) wr(OFS[i], 8'h00);
    for (int i = 0; i < 12; i++) rd(OFS[i], RZ[i]);
  endtask

  task automatic t_cnv();
    i_cnv = {12'hA5C, 8'h7E};
    i_cnv_valid = 1'b1;
    tick(1);
    i_cnv_valid = 1'b0;
    i_cnv = '1;
    rd(8'h54, 8'hA5);
    rd(8'h55, 8'hC0);
    rd(8'h56, 8'h7E);
  endtask

  task automatic t_irq();
    do_reset();
    wr(8'h5C, 8'h18);
    i_irq_live = 8'h01;
    tick(1);
    chk("pin live", 1'b0, o_interrupt_pin);
    i_irq_mask = 8'h01;
    tick(1);
    chk("pin masked", 1'b1, o_interrupt_pin);
    i_irq_mask = 8'h00;
    i_irq_live = 8'h00;
    wr(8'h5C, 8'h19);
    i_irq_live = 8'h08;
    tick(1);
    i_irq_live = 8'h00;
    tick(2);
    // bit 0 was latched during the live-mode steps, masked or not
    chk("latched flags", 8'h09, o_irq_latched);
    chk("pin latched", 1'b0, o_interrupt_pin);
    wr(8'h5C, 8'h1D);
    tick(2);
    chk("latches cleared", 8'h00, o_irq_latched);
    chk("pin after clear", 1'b1, o_interrupt_pin);
    rd(8'h5C, 8'h19);
    wr(8'h5D, 8'h00);
    i_irq_live = 8'h01;
    tick(3);
    chk("pin active high", 1'b1, o_interrupt_pin);
    i_irq_live = 8'h00;
  endtask

  task automatic t_pulse();
    int n;
    do_reset();
    wr(8'h5D, 8'h00);
    wr(8'h5C, 8'h1A);
    i_irq_live = 8'h01;
    run_len(1'b0, 15, n);
    run_len(1'b1, 60, n);
    chk("pulse length", 1'b1, n >= 20 && n <= 40);
    run_len(1'b0, 60, n);
    chk("no second pulse", 60, n);
    wr(8'h5C, 8'h1B);
    run_len(1'b0, 45, n);
    chk("repeat pulse", 1'b1, n < 45);
    run_len(1'b1, 60, n);
    run_len(1'b0, 45, n);
    chk("repeat again", 1'b1, n < 45);
    i_irq_live = 8'h00;
  endtask

  task automatic t_halt(input logic [2:0] code);
    int n;
    do_reset();
    i_audio_clk_present = 1'b1;
    wr(8'h5C, {2'b10, code, 3'b001});
    tick(6);
    chk("power with clocks", 1'b1, o_power_up);
    i_rate_invalid = 1'b1;
    tick(1);
    i_rate_invalid = 1'b0;
    chk("clock error", 1'b1, o_clock_error);
    i_audio_clk_present = 1'b0;
    n = 0;
    while (o_clock_halted !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("halt delay", 1'b1, n + 2 >= HC[code] && n <= HC[code] + 6);
    tick(2);
    chk("power after halt", 1'b0, o_power_up);
  endtask

  task automatic t_halt_off();
    do_reset();
    i_audio_clk_present = 1'b1;
    wr(8'h5C, 8'h59);
    i_rate_changed = 1'b1;
    tick(1);
    i_rate_changed = 1'b0;
    chk("error on change", 1'b1, o_clock_error);
    i_audio_clk_present = 1'b0;
    tick(40);
    chk("no halt", 1'b0, o_clock_halted);
    chk("error released", 1'b0, o_clock_error);
    chk("manual power", 1'b1, o_power_up);
  endtask

  task automatic t_ratio();
    do_reset();
    i_ratio_detected = 6'h0B;
    i_ratio_detected_valid = 1'b1;
    tick(1);
    i_ratio_detected_valid = 1'b0;
    rd(8'h68, 8'h0B);
    chk("no ratio error", 1'b0, o_clock_error);
    i_auto_rate_off = 1'b1;
    wr(8'h60, 8'h15);
    tick(2);
    chk("ratio field", 6'h05, o_cfg.frame_ratio_setting);
    rd(8'h60, 8'h15);
    // same detected code as before, so only the fixed-setting check trips
    i_ratio_detected_valid = 1'b1;
    tick(1);
    i_ratio_detected_valid = 1'b0;
    chk("ratio mismatch error", 1'b1, o_clock_error);
    i_auto_rate_off = 1'b0;
  endtask

  // a hang ends the run through the same report
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    t_regs();
    t_cnv();
    t_irq();
    t_pulse();
    t_halt(3'h3);
    t_halt(3'h0);
    t_halt_off();
    t_ratio();
    print_verdict();
  end
endmodule
